//--- rtl/arct_timer.sv
// Purpose: 16-bit auto-reload timer/counter with combined control register
// Assumes: pins are asynchronous; vector_ack comes from the core on pclk
// Notes:   APB slave, zero wait states, error on unmapped address
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module arct_timer
	import arct_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic        count_input_pin,
	input  wire logic        ext_irq_a_pin,
	input  wire logic        ext_irq_b_pin,
	// core side
	input  wire logic        vector_ack,
	output logic             timer_irq_req,
	output logic             irq
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic [2:0] pin_prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= ARCT_PIN_IDLE;
			pin_sync_r <= ARCT_PIN_IDLE;
			pin_prev_r <= ARCT_PIN_IDLE;
		end else begin
			pin_meta_r <= {ext_irq_b_pin, ext_irq_a_pin, count_input_pin};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// falling edges on the interrupt pins, as the classic core detects
	logic a_fall;
	logic b_fall;
	assign a_fall = pin_prev_r[1] & ~pin_sync_r[1];
	assign b_fall = pin_prev_r[2] & ~pin_sync_r[2];

	// ----------------------------------------
	// machine cycle
	// ----------------------------------------
	arct_slot_t slot;

	arct_mcycle u_mcycle (
		.pclk    (pclk),
		.presetn (presetn),
		.slot    (slot)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic wr_en;
	logic rd_setup;
	logic mapped;
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			ARCT_OFF_CTRL, ARCT_OFF_COUNT_LO, ARCT_OFF_COUNT_HI,
			ARCT_OFF_RELOAD_LO, ARCT_OFF_RELOAD_HI,
			ARCT_OFF_IRQ_STAT, ARCT_OFF_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	logic wr_ctrl;
	logic wr_lo;
	logic wr_hi;
	assign wr_ctrl = wr_en && paddr == ARCT_OFF_CTRL;
	assign wr_lo   = wr_en && paddr == ARCT_OFF_COUNT_LO;
	assign wr_hi   = wr_en && paddr == ARCT_OFF_COUNT_HI;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	arct_ctrl_t ctrl_r;
	arct_ctrl_t wctl;
	assign wctl = arct_ctrl_t'(pwdata[7:0]);

	// ----------------------------------------
	// count enable
	// ----------------------------------------
	logic pin_event_r;
	logic gate_ok;
	logic step;
	logic [15:0] count_r;
	logic [15:0] reload_r;
	logic overflow;

	// pin sampled at the fixed slot, transition counted on the next sample
	logic pin_sampled_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sampled_r <= 1'b0;
			pin_event_r   <= 1'b0;
		end else if (slot.sample) begin
			pin_sampled_r <= pin_sync_r[0];                         // [R1]
			pin_event_r   <= pin_sampled_r & ~pin_sync_r[0];        // [R1]
		end else if (slot.tick) begin
			pin_event_r   <= 1'b0;
		end
	end

	assign gate_ok  = ~ctrl_r.gate | pin_sync_r[1];                  // [R12]
	assign step     = ctrl_r.run & gate_ok & slot.tick &             // [R5] [R12]
	                  (ctrl_r.src_pin ? pin_event_r : 1'b1);          // [R3] [R4]
	assign overflow = step & (count_r == 16'hffff);

	// ----------------------------------------
	// counter and reload
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= {ARCT_BYTE_RST, ARCT_BYTE_RST};
		end else if (overflow) begin
			count_r <= reload_r;                                       // [R7] [R2]
		end else if (step) begin
			count_r <= count_r + 16'h0001;                             // [R6]
		end else if (wr_lo) begin
			count_r[7:0] <= pwdata[7:0];
		end else if (wr_hi) begin
			count_r[15:8] <= pwdata[7:0];
		end
	end

	// only software changes the reload pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_r <= {ARCT_BYTE_RST, ARCT_BYTE_RST};
		end else if (wr_en && paddr == ARCT_OFF_RELOAD_LO) begin
			reload_r[7:0] <= pwdata[7:0];                              // [R8]
		end else if (wr_en && paddr == ARCT_OFF_RELOAD_HI) begin
			reload_r[15:8] <= pwdata[7:0];                             // [R8]
		end
	end

	// ----------------------------------------
	// control register, flags set by hardware
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= arct_ctrl_t'(ARCT_CTRL_RST);
		end else begin
			if (wr_ctrl) begin
				ctrl_r.gate    <= wctl.gate;
				ctrl_r.src_pin <= wctl.src_pin;
				ctrl_r.run     <= wctl.run;
				ctrl_r.a_type  <= wctl.a_type;                        // [R10]
				ctrl_r.b_type  <= wctl.b_type;                        // [R11]
			end
			// set wins over a software write or a vector clear
			if (overflow) begin
				ctrl_r.ovf <= 1'b1;                                   // [R9]
			end else if (vector_ack) begin
				ctrl_r.ovf <= 1'b0;                                   // [R13]
			end else if (wr_ctrl) begin
				ctrl_r.ovf <= wctl.ovf;
			end
			// level mode follows the inverted pin; edge mode latches a falling edge
			if (!ctrl_r.a_type) begin
				ctrl_r.a_edge <= ~pin_sync_r[1];                      // [R10]
			end else if (a_fall) begin
				ctrl_r.a_edge <= 1'b1;                                // [R10]
			end else if (wr_ctrl) begin
				ctrl_r.a_edge <= wctl.a_edge;
			end
			if (!ctrl_r.b_type) begin
				ctrl_r.b_edge <= ~pin_sync_r[2];                      // [R11]
			end else if (b_fall) begin
				ctrl_r.b_edge <= 1'b1;                                // [R11]
			end else if (wr_ctrl) begin
				ctrl_r.b_edge <= wctl.b_edge;
			end
		end
	end

	assign timer_irq_req = ctrl_r.ovf;                               // [R9]

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_set;
	logic       irq_pend;
	assign irq_set  = {b_fall & ctrl_r.b_type, a_fall & ctrl_r.a_type, overflow};
	assign irq_pend = |(irq_stat_r & irq_mask_r);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_stat_r[gi] <= 1'b0;
				end else if (irq_set[gi]) begin
					irq_stat_r[gi] <= 1'b1;
				end else if (wr_en && paddr == ARCT_OFF_IRQ_STAT && pwdata[gi]) begin
					irq_stat_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= ARCT_IRQ_RST;
		end else if (wr_en && paddr == ARCT_OFF_IRQ_MASK) begin
			irq_mask_r <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_pend;                                          // [R9]
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// captured in the setup cycle: the word stands from a flop all through
	// the access phase, at the cost of missing a step landing meanwhile
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			ARCT_OFF_CTRL:      rd_word[7:0] = ctrl_r;
			ARCT_OFF_COUNT_LO:  rd_word[7:0] = count_r[7:0];
			ARCT_OFF_COUNT_HI:  rd_word[7:0] = count_r[15:8];
			ARCT_OFF_RELOAD_LO: rd_word[7:0] = reload_r[7:0];
			ARCT_OFF_RELOAD_HI: rd_word[7:0] = reload_r[15:8];
			ARCT_OFF_IRQ_STAT:  rd_word[2:0] = irq_stat_r;
			ARCT_OFF_IRQ_MASK:  rd_word[2:0] = irq_mask_r;
			default:            rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_word;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// a software reload write landing with the wrap may change the pair
	logic wr_rel;
	assign wr_rel = wr_en && (paddr == ARCT_OFF_RELOAD_LO || paddr == ARCT_OFF_RELOAD_HI);

	sequence s_wrap;
		overflow && !wr_rel ##1 1'b1;
	endsequence

	a_reload_value: assert property (@(posedge pclk) disable iff (!presetn)
		overflow |=> count_r == $past(reload_r))
		else $error("counter not reloaded on overflow");        // [R7]
	a_reload_kept: assert property (@(posedge pclk) disable iff (!presetn)
		s_wrap |-> reload_r == $past(reload_r))
		else $error("reload changed by overflow");              // [R8]
	a_step_incr: assert property (@(posedge pclk) disable iff (!presetn)
		step && !overflow |=> count_r == $past(count_r) + 16'h0001)
		else $error("counter did not increment");               // [R6]
	a_run_stop: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_r.run && !wr_lo && !wr_hi |=> $stable(count_r))
		else $error("counter moved while stopped");             // [R5]
	a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r.gate && !pin_sync_r[1] |-> !step)
		else $error("counter stepped with gate low");           // [R12]
	a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
		overflow |=> ctrl_r.ovf && irq_stat_r[ARCT_IRQ_OVF])
		else $error("overflow flag not set");                   // [R9]
	a_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
		vector_ack && !overflow |=> !ctrl_r.ovf)
		else $error("overflow flag not cleared on vector");     // [R13]
	a_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r.a_type && a_fall |=> ctrl_r.a_edge)
		else $error("irq a edge not flagged");                  // [R10]
	a_edge_b: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r.b_type && b_fall |=> ctrl_r.b_edge)
		else $error("irq b edge not flagged");                  // [R11]
	a_pin_sync: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r.src_pin && step |-> pin_event_r)
		else $error("pin mode step without a transition");      // [R4] [R1]
	a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		irq_pend |=> irq)
		else $error("interrupt not raised for pending status"); // [R9]

endmodule

//--- rtl/arct_pkg.sv
// Purpose: constants and types for the auto-reload timer/counter block
// Assumes: 250 MHz pclk stands in for the oscillator; APB register access
// Notes:   register offsets are byte addresses on 32-bit words
//
// How it works
// R1: count pin sampled once per machine cycle slot
// R2: one 16-bit counter with auto reload
// R3: source is osc/12 or count pin transitions
// R4: control bit 6 selects pin counting
// R5: counting only while run enable bit 4
// R6: each event increments high/low pair together
// R7: overflow reloads pair from reload registers
// R8: reload leaves reload registers unchanged
// R9: overflow sets flag bit 5, requests interrupt
// R10: irq a type bit 2, edge flag 3
// R11: irq b edge flag bit 1, type 0
// R12: gate bit 7 needs irq a pin high
// R13: overflow flag cleared on vector, reset
package arct_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ARCT_OFF_CTRL      = 8'h00;
	localparam logic [7:0] ARCT_OFF_COUNT_LO  = 8'h04;
	localparam logic [7:0] ARCT_OFF_COUNT_HI  = 8'h08;
	localparam logic [7:0] ARCT_OFF_RELOAD_LO = 8'h0c;
	localparam logic [7:0] ARCT_OFF_RELOAD_HI = 8'h10;
	localparam logic [7:0] ARCT_OFF_IRQ_STAT  = 8'h14;
	localparam logic [7:0] ARCT_OFF_IRQ_MASK  = 8'h18;

	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int ARCT_BIT_GATE      = 7;
	localparam int ARCT_BIT_SRC_PIN   = 6;
	localparam int ARCT_BIT_OVF       = 5;
	localparam int ARCT_BIT_RUN       = 4;
	localparam int ARCT_BIT_A_EDGE    = 3;
	localparam int ARCT_BIT_A_TYPE    = 2;
	localparam int ARCT_BIT_B_EDGE    = 1;
	localparam int ARCT_BIT_B_TYPE    = 0;

	// interrupt status / mask bits
	localparam int ARCT_IRQ_OVF       = 0;
	localparam int ARCT_IRQ_A         = 1;
	localparam int ARCT_IRQ_B         = 2;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0]  ARCT_CTRL_RST   = 8'h00;
	localparam logic [7:0]  ARCT_BYTE_RST   = 8'h00;
	localparam logic [2:0]  ARCT_IRQ_RST    = 3'h0;
	// pins idle high: synchronisers start there, so no false edge after reset
	localparam logic [2:0]  ARCT_PIN_IDLE   = 3'h7;
	localparam int          ARCT_MC_DIV     = 12;
	localparam logic [3:0]  ARCT_MC_LAST    = 4'(ARCT_MC_DIV - 1);
	// slot inside the machine cycle where the count pin is sampled
	localparam logic [3:0]  ARCT_SAMPLE_SLOT = 4'h6;

	typedef struct packed {
		logic gate;
		logic src_pin;
		logic ovf;
		logic run;
		logic a_edge;
		logic a_type;
		logic b_edge;
		logic b_type;
	} arct_ctrl_t;

	typedef struct packed {
		logic       tick;
		logic       sample;
	} arct_slot_t;

endpackage

//--- rtl/arct_mcycle.sv
// Purpose: machine cycle divider, one pulse per twelve clocks
// Assumes: single pclk domain
// Notes:   also marks the pin sampling slot
`timescale 1ns/1ps
module arct_mcycle
	import arct_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// slot pulses
	output arct_slot_t      slot
);

	logic [3:0] phase_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= 4'h0;
		end else if (phase_r == ARCT_MC_LAST) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= phase_r + 4'h1;
		end
	end

	assign slot.tick   = (phase_r == ARCT_MC_LAST);       // [R3]
	assign slot.sample = (phase_r == ARCT_SAMPLE_SLOT);   // [R1]

	a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
		slot.tick |=> !slot.tick [*8])
		else $error("machine cycle tick repeats too soon");  // [R3]

endmodule

//--- dv/arct_pin_src.sv
// Purpose: far side model, count pulse source, irq pins and core vector ack
// Assumes: pins idle high; changes land just after a rising edge
// Notes:   each count pin level is held 16 cycles, longer than one machine cycle
`timescale 1ns/1ps
module arct_pin_src (
	// clock
	input  wire logic pclk,
	// pins and core side
	output logic      count_input_pin,
	output logic      ext_irq_a_pin,
	output logic      ext_irq_b_pin,
	output logic      vector_ack
);
	initial begin
		count_input_pin = 1'b1;
		ext_irq_a_pin   = 1'b1;
		ext_irq_b_pin   = 1'b1;
		vector_ack      = 1'b0;
	end

	// 16 cycles per level, above the 12 needed for one sample per machine cycle
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge pclk) count_input_pin <= 1'b0;
			repeat (16) @(posedge pclk);
			count_input_pin <= 1'b1;
			repeat (16) @(posedge pclk);
		end
	endtask

	task automatic set_a(input logic v);
		@(posedge pclk) ext_irq_a_pin <= v;
	endtask

	task automatic set_b(input logic v);
		@(posedge pclk) ext_irq_b_pin <= v;
	endtask

	// one-cycle pulse as the core gives on vectoring
	task automatic ack();
		@(posedge pclk) vector_ack <= 1'b1;
		@(posedge pclk) vector_ack <= 1'b0;
	endtask
endmodule

//--- dv/arct_timer_tb.sv
// Purpose: self-checking bench for the auto-reload timer/counter
// Assumes: zero wait state apb slave, pins driven by arct_pin_src
// Notes:   every wait is bounded
`timescale 1ns/1ps
module arct_timer_tb;
	import arct_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cnt_pin, pin_a, pin_b, vack;
	logic        timer_irq_req, irq;
	logic        last_err;
	logic [31:0] q;
	int          errors = 0;
	int          n_checks = 0;

	always #2 pclk = ~pclk;

	arct_pin_src src (.pclk(pclk), .count_input_pin(cnt_pin), .ext_irq_a_pin(pin_a),
		.ext_irq_b_pin(pin_b), .vector_ack(vack));

	arct_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .count_input_pin(cnt_pin),
		.ext_irq_a_pin(pin_a), .ext_irq_b_pin(pin_b), .vector_ack(vack),
		.timer_irq_req(timer_irq_req), .irq(irq));

	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			close_out();
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(n, e, q);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_map();
		chk("pready", 32'h1, {31'h0, pready});
		rdc("ctrl", ARCT_OFF_CTRL, 32'h0);
		rdc("count_hi", ARCT_OFF_COUNT_HI, 32'h0);
		rdc("reload_lo", ARCT_OFF_RELOAD_LO, 32'h0);
		rdc("irq_stat", ARCT_OFF_IRQ_STAT, 32'h0);
		rdc("irq_mask", ARCT_OFF_IRQ_MASK, 32'h0);
		rdc("unmapped", 8'h1c, 32'h0);
		chk("pslverr", 32'h1, {31'h0, last_err});
	endtask

	// overflow from 0xffff reloads, flags, interrupt raise, mask, clear
	task automatic t_overflow();
		int k;
		wr(ARCT_OFF_RELOAD_LO, 32'hfe);
		wr(ARCT_OFF_RELOAD_HI, 32'h12);
		wr(ARCT_OFF_COUNT_LO, 32'hfd);
		wr(ARCT_OFF_COUNT_HI, 32'hff);
		wr(ARCT_OFF_CTRL, 32'h10);
		k = 0;
		while (timer_irq_req !== 1'b1 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		chk("ovf_wait", 32'h1, {31'h0, timer_irq_req});
		wr(ARCT_OFF_CTRL, 32'h20);
		rdc("ctrl", ARCT_OFF_CTRL, 32'h20);
		rdc("count_lo", ARCT_OFF_COUNT_LO, 32'hfe);
		rdc("count_hi", ARCT_OFF_COUNT_HI, 32'h12);
		rdc("reload_lo", ARCT_OFF_RELOAD_LO, 32'hfe);
		rdc("reload_hi", ARCT_OFF_RELOAD_HI, 32'h12);
		rdc("irq_stat", ARCT_OFF_IRQ_STAT, 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq});
		repeat (40) @(posedge pclk);
		rdc("count_stopped", ARCT_OFF_COUNT_LO, 32'hfe);
		wr(ARCT_OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		src.ack();
		repeat (2) @(posedge pclk);
		chk("ovf_after_ack", 32'h0, {31'h0, timer_irq_req});
		wr(ARCT_OFF_IRQ_STAT, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq_cleared", 32'h0, {31'h0, irq});
	endtask

	// pin mode counts falling transitions only, not the divided clock
	task automatic t_pin_count();
		wr(ARCT_OFF_COUNT_LO, 32'h0);
		wr(ARCT_OFF_COUNT_HI, 32'h0);
		wr(ARCT_OFF_CTRL, 32'h50);
		src.pulse(3);
		repeat (30) @(posedge pclk);
		wr(ARCT_OFF_CTRL, 32'h0);
		rdc("pin_count_lo", ARCT_OFF_COUNT_LO, 32'h3);
		rdc("pin_count_hi", ARCT_OFF_COUNT_HI, 32'h0);
	endtask

	// gate bit holds the counter while irq a pin is low
	task automatic t_gate();
		wr(ARCT_OFF_COUNT_LO, 32'h0);
		src.set_a(1'b0);
		wr(ARCT_OFF_CTRL, 32'h90);
		repeat (60) @(posedge pclk);
		rdc("gated_count", ARCT_OFF_COUNT_LO, 32'h0);
		rdc("level_flag", ARCT_OFF_CTRL, 32'h98);
		src.set_a(1'b1);
		repeat (60) @(posedge pclk);
		wr(ARCT_OFF_CTRL, 32'h0);
		apb(ARCT_OFF_COUNT_LO, 1'b0, 32'h0);
		chk("ungated_runs", 32'h1, {31'h0, q === 32'h5 || q === 32'h6});
	endtask

	// edge mode on both irq inputs sets sticky flags in ctrl and status
	task automatic t_edges();
		wr(ARCT_OFF_IRQ_STAT, 32'h7);
		wr(ARCT_OFF_CTRL, 32'h05);
		src.set_a(1'b0);
		repeat (10) @(posedge pclk);
		src.set_a(1'b1);
		repeat (10) @(posedge pclk);
		rdc("edge_a", ARCT_OFF_CTRL, 32'h0d);
		src.set_b(1'b0);
		repeat (10) @(posedge pclk);
		src.set_b(1'b1);
		repeat (10) @(posedge pclk);
		rdc("edge_b", ARCT_OFF_CTRL, 32'h0f);
		rdc("edge_stat", ARCT_OFF_IRQ_STAT, 32'h6);
	endtask

	// reset in mid-run clears the overflow flag, run bit and counter
	task automatic t_mid_reset();
		wr(ARCT_OFF_COUNT_LO, 32'h34);
		wr(ARCT_OFF_CTRL, 32'h30);
		repeat (20) @(posedge pclk);
		chk("irq_req_before_reset", 32'h1, {31'h0, timer_irq_req});
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("irq_req_after_reset", 32'h0, {31'h0, timer_irq_req});
		rdc("ctrl_after_reset", ARCT_OFF_CTRL, 32'h0);
		repeat (30) @(posedge pclk);
		rdc("count_after_reset", ARCT_OFF_COUNT_LO, 32'h0);
	endtask

	initial begin
		pclk    <= 1'b0;
		presetn <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 8'h00;
		pwdata  <= 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset_map();
		t_overflow();
		t_pin_count();
		t_gate();
		t_edges();
		t_mid_reset();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		close_out();
	end
endmodule
